// >>> hdl/channel_match.sv
// Purpose: One comparator channel: address, optional data and bus state
// Assumes: Bus inputs synchronous to clk_sys, one access per cycle
// Notes: Match is registered, one cycle after the qualifying access
`timescale 1ns/1ps
`default_nettype none
module channel_match
   import event_trigger_pkg::*;
#(
   parameter bit HAS_DATA = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bus activity
   input wire logic access_valid,
   input wire logic [ADDR_W-1:0] access_addr,
   input wire logic [DATA_W-1:0] access_data,
   input wire logic access_write,
   input wire event_trigger_pkg::acc_size_t access_size,
   input wire logic pc_before_valid,
   input wire logic pc_after_valid,
   input wire logic [ADDR_W-1:0] pc,
   // Configuration
   input wire logic enable,
   input wire event_trigger_pkg::addr_src_t addr_src,
   input wire logic [ADDR_W-1:0] addr_value,
   input wire logic data_enable,
   input wire logic [DATA_W-1:0] data_value,
   input wire event_trigger_pkg::acc_size_t data_size,
   input wire event_trigger_pkg::acc_dir_t dir_sel,
   // Result
   output logic hit
);
   logic addr_ok;
   logic data_ok;
   logic dir_ok;
   logic [DATA_W-1:0] mask;

   always_comb begin
      case (addr_src)
         ADDR_DATA: addr_ok = access_valid && access_addr == addr_value;
         ADDR_PC_BEFORE: addr_ok = pc_before_valid && pc == addr_value;
         ADDR_PC_AFTER: addr_ok = pc_after_valid && pc == addr_value;
         default: addr_ok = 1'b0;
      endcase
   end

   always_comb begin
      case (data_size)
         SIZE_BYTE: mask = 32'h0000_00FF;
         SIZE_WORD: mask = 32'h0000_FFFF;
         default: mask = 32'hFFFF_FFFF;
      endcase
      data_ok = !HAS_DATA || !data_enable ||
         (access_valid && access_size == data_size &&
          (access_data & mask) == (data_value & mask));
      case (dir_sel)
         DIR_READ: dir_ok = !HAS_DATA || (access_valid && !access_write);
         DIR_WRITE: dir_ok = !HAS_DATA || (access_valid && access_write);
         default: dir_ok = 1'b1;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hit <= 1'b0;
      end else begin
         hit <= enable && addr_ok && data_ok && dir_ok;
      end
   end

endmodule // channel_match
`default_nettype wire

// >>> hdl/event_trigger_pkg.sv
// Purpose: Shared constants and types for the debug event-condition block
// Assumes: One 40 MHz core bus clock, active-low asynchronous reset
// Notes: Channel numbering is 1-based in names, 0-based in vectors
`default_nettype none
package event_trigger_pkg;

   // ----------------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------------
   localparam int NUM_CH = 11;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int COUNT_W = 16;
   localparam int PERF_W = 32;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [PERF_W-1:0] PERF_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ADDR_DATA, ADDR_PC_BEFORE, ADDR_PC_AFTER
   } addr_src_t;

   typedef enum logic [1:0] {
      SIZE_BYTE, SIZE_WORD, SIZE_LONG
   } acc_size_t;

   typedef enum logic [1:0] {
      DIR_EITHER, DIR_READ, DIR_WRITE
   } acc_dir_t;

   // Sequencer selector for channels 1, 2, 3 and 11
   typedef enum logic [3:0] {
      SEQ_OFF,
      SEQ_321, SEQ_321_RP, SEQ_21, SEQ_21_RP,
      PERF_2_TO_1, PERF_1_TO_2
   } seq_mode_t;

   typedef enum logic [1:0] {
      WIN_OFF, WIN_5_TO_4, WIN_5_TO_4_POR
   } win_mode_t;

endpackage

`default_nettype wire

// >>> hdl/event_trigger_sequencer.sv
// Purpose: Debug event conditions, sequencer, perf gate and trace window
// Assumes: Configuration ports held stable except when cfg_write pulses
// Notes: Actions are one-cycle pulses or registered levels
//
// Contract
// (RULE1) Address match on data address or PC
// (RULE2) Data match with byte/word/long size
// (RULE3) Bus state qualifies by read/write/either
// (RULE4) Ch1 full, Ch2 no count, others address
// (RULE5) Count fires after N qualified matches
// (RULE6) Ch1/2: break, halt, qualify, perf
// (RULE7) Ch4/5 add window; others break, halt
// (RULE8) Sequence 3 then 2 then 1
// (RULE9) Sequence 2 then 1
// (RULE10) Sequence end gives break or halt
// (RULE11) Ch11 reset point or Ch1 count
// (RULE12) Reset point restarts sequence
// (RULE13) Sequence must repeat programmed count times
// (RULE14) Perf runs 2-to-1 or 1-to-2
// (RULE15) Restart after end accumulates
// (RULE16) Window opens on Ch5, closes Ch4
// (RULE17) Window variant also closes on power-on
// (RULE18) Fresh Ch5 reopens closed window
// (RULE19) Off selectors leave channels independent
// (RULE20) Halt watchdog during debug break
// (RULE21) Config write clears stage, count, pending
`timescale 1ns/1ps
`default_nettype none
module event_trigger_sequencer
   import event_trigger_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Core bus activity
   input wire logic access_valid,
   input wire logic [ADDR_W-1:0] access_addr,
   input wire logic [DATA_W-1:0] access_data,
   input wire logic access_write,
   input wire event_trigger_pkg::acc_size_t access_size,
   input wire logic pc_before_valid,
   input wire logic pc_after_valid,
   input wire logic [ADDR_W-1:0] pc,
   input wire logic power_on_reset,
   input wire logic cpu_in_break,
   // Channel configuration
   input wire logic cfg_write,
   input wire logic [NUM_CH-1:0] ch_enable,
   input wire event_trigger_pkg::addr_src_t [NUM_CH-1:0] ch_addr_src,
   input wire logic [NUM_CH-1:0][ADDR_W-1:0] ch_addr,
   input wire logic [1:0] ch_data_enable,
   input wire logic [1:0][DATA_W-1:0] ch_data,
   input wire event_trigger_pkg::acc_size_t [1:0] ch_data_size,
   input wire event_trigger_pkg::acc_dir_t [1:0] ch_dir,
   input wire logic ch1_count_enable,
   input wire logic [COUNT_W-1:0] ch1_count,
   // Action selection
   input wire logic [NUM_CH-1:0] act_break,
   input wire logic [NUM_CH-1:0] act_trace_halt,
   input wire logic [1:0] act_trace_qualify,
   input wire event_trigger_pkg::seq_mode_t seq_mode,
   input wire logic seq_halts_trace,
   input wire event_trigger_pkg::win_mode_t trace_window_mode,
   // Results
   output logic break_req,
   output logic trace_halt,
   output logic trace_qualify,
   output logic trace_window_open,
   output logic perf_active,
   output logic [PERF_W-1:0] perf_count,
   output logic [NUM_CH-1:0] ch_hit,
   output logic [COUNT_W-1:0] occurrence,
   output logic [1:0] seq_stage,
   output logic watchdog_timer_stop
);
   // ----------------------------------------------------------------------
   // Comparators
   // ----------------------------------------------------------------------
   logic [NUM_CH-1:0] hit;
   logic seq_on;
   logic seq3;
   logic rp_on;
   logic perf_on;
   logic win_on;
   logic count_on;
   logic count_done;
   logic [COUNT_W-1:0] next_occurrence;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         channel_match #(.HAS_DATA(g < 2)) u_ch ( // RULE4
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .access_valid(access_valid),
            .access_addr(access_addr),
            .access_data(access_data),
            .access_write(access_write),
            .access_size(access_size),
            .pc_before_valid(pc_before_valid),
            .pc_after_valid(pc_after_valid),
            .pc(pc),
            .enable(ch_enable[g] && !cfg_write),
            .addr_src(ch_addr_src[g]), // RULE1
            .addr_value(ch_addr[g]),
            .data_enable(g < 2 ? ch_data_enable[g % 2] : 1'b0), // RULE2
            .data_value(ch_data[g % 2]),
            .data_size(ch_data_size[g % 2]),
            .dir_sel(g < 2 ? ch_dir[g % 2] : DIR_EITHER), // RULE3
            .hit(hit[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   always_comb begin
      seq_on = seq_mode inside {SEQ_321, SEQ_321_RP, SEQ_21, SEQ_21_RP};
      seq3 = seq_mode inside {SEQ_321, SEQ_321_RP};
      rp_on = seq_mode inside {SEQ_321_RP, SEQ_21_RP}; // RULE11
      perf_on = seq_mode inside {PERF_2_TO_1, PERF_1_TO_2};
      win_on = trace_window_mode != WIN_OFF;
      // Ch1 count is used only when Ch11 is not a reset point
      count_on = ch1_count_enable && !rp_on; // RULE11
      next_occurrence = occurrence + 16'h0001;
      count_done = !count_on || next_occurrence >= ch1_count;
   end

   // ----------------------------------------------------------------------
   // Sequencer stage and occurrence counter
   // ----------------------------------------------------------------------
   // Stage 0 waits for the first channel, 1 for Ch2 (3-2-1), 2 for Ch1.
   logic ch1_event;
   logic seq_done;

   always_comb begin
      ch1_event = 1'b0;
      seq_done = 1'b0;
      if (seq_on) begin
         seq_done = seq_stage == 2'd2 && hit[0] && !(rp_on && hit[10]);
         ch1_event = seq_done;
      end else if (!perf_on) begin
         ch1_event = hit[0]; // RULE19
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         seq_stage <= 2'd0;
      end else if (cfg_write || power_on_reset || !seq_on) begin
         seq_stage <= 2'd0; // RULE21
      end else if (rp_on && hit[10]) begin
         seq_stage <= 2'd0; // RULE12
      end else begin
         case (seq_stage)
            2'd0: begin
               if (seq3 && hit[2]) begin
                  seq_stage <= 2'd1; // RULE8
               end else if (!seq3 && hit[1]) begin
                  seq_stage <= 2'd2; // RULE9
               end
            end
            2'd1: begin
               if (hit[1]) begin
                  seq_stage <= 2'd2; // RULE8
               end
            end
            2'd2: begin
               if (hit[0]) begin
                  seq_stage <= 2'd0;
               end
            end
            default: seq_stage <= 2'd0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         occurrence <= COUNT_RESET;
      end else if (cfg_write || !count_on) begin
         occurrence <= COUNT_RESET; // RULE21
      end else if (ch1_event) begin
         // Counts qualified matches, or whole sequences when sequenced
         occurrence <= count_done ? COUNT_RESET : next_occurrence; // RULE5 RULE13
      end
   end

   // ----------------------------------------------------------------------
   // Actions
   // ----------------------------------------------------------------------
   logic ch1_fire;
   logic [NUM_CH-1:0] fire;

   always_comb begin
      ch1_fire = ch1_event && count_done; // RULE5
      fire = hit;
      fire[0] = ch1_fire && !seq_on;
      // Sequenced or perf channels give up their own actions
      if (seq_on || perf_on) begin
         fire[1] = 1'b0;
         fire[2] = 1'b0;
      end
      if (rp_on) begin
         fire[10] = 1'b0;
      end
      if (win_on) begin
         fire[3] = 1'b0; // RULE19
         fire[4] = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         break_req <= 1'b0;
         trace_halt <= 1'b0;
      end else if (cfg_write) begin
         break_req <= 1'b0; // RULE21
         trace_halt <= 1'b0;
      end else if (seq_on) begin
         break_req <= (|(fire & act_break)) ||
            (ch1_fire && !seq_halts_trace); // RULE10
         trace_halt <= (|(fire & act_trace_halt)) ||
            (ch1_fire && seq_halts_trace); // RULE10
      end else begin
         break_req <= |(fire & act_break); // RULE6 RULE7
         trace_halt <= |(fire & act_trace_halt); // RULE6 RULE7
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trace_qualify <= 1'b0;
      end else begin
         trace_qualify <= |(fire[1:0] & act_trace_qualify); // RULE6
      end
   end

   // ----------------------------------------------------------------------
   // Performance gate
   // ----------------------------------------------------------------------
   logic perf_start;
   logic perf_end;

   always_comb begin
      perf_start = seq_mode == PERF_2_TO_1 ? hit[1] : hit[0]; // RULE14
      perf_end = seq_mode == PERF_2_TO_1 ? hit[0] : hit[1]; // RULE14
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         perf_active <= 1'b0;
      end else if (cfg_write || !perf_on) begin
         perf_active <= 1'b0;
      end else if (perf_end) begin
         perf_active <= 1'b0;
      end else if (perf_start) begin
         perf_active <= 1'b1; // RULE15
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         perf_count <= PERF_RESET;
      end else if (perf_active) begin
         // Never cleared by a restart; sums all intervals
         perf_count <= perf_count + 32'h0000_0001; // RULE15
      end
   end

   // ----------------------------------------------------------------------
   // Trace window
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trace_window_open <= 1'b0;
      end else if (cfg_write || !win_on) begin
         trace_window_open <= 1'b0;
      end else if (trace_window_mode == WIN_5_TO_4_POR && power_on_reset) begin
         trace_window_open <= 1'b0; // RULE17
      end else if (hit[3]) begin
         trace_window_open <= 1'b0; // RULE16
      end else if (hit[4]) begin
         trace_window_open <= 1'b1; // RULE16 RULE18
      end
   end

   // ----------------------------------------------------------------------
   // Watchdog hold and hit status
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         watchdog_timer_stop <= 1'b0;
         ch_hit <= '0;
      end else begin
         watchdog_timer_stop <= cpu_in_break; // RULE20
         ch_hit <= hit;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_wdt;
      @(posedge clk_sys) disable iff (!rst_b)
      cpu_in_break |=> watchdog_timer_stop;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog not held"); // RULE20

   property p_rp;
      @(posedge clk_sys) disable iff (!rst_b)
      (rp_on && hit[10] && !cfg_write) |=> seq_stage == 2'd0;
   endproperty
   a_rp: assert property (p_rp) else $error("reset point ignored"); // RULE12

   property p_cfg;
      @(posedge clk_sys) disable iff (!rst_b)
      cfg_write |=> (seq_stage == 2'd0 && occurrence == COUNT_RESET &&
         !break_req && !trace_halt);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config clear lost"); // RULE21

   property p_seq;
      @(posedge clk_sys) disable iff (!rst_b)
      (seq3 && seq_stage == 2'd0) |=> seq_stage != 2'd2;
   endproperty
   a_seq: assert property (p_seq) else $error("sequence skipped"); // RULE8

   property p_seq21;
      @(posedge clk_sys) disable iff (!rst_b)
      (seq_on && !seq3 && seq_stage == 2'd0 && hit[1] && !hit[10] &&
         !cfg_write && !power_on_reset) |=> seq_stage == 2'd2;
   endproperty
   a_seq21: assert property (p_seq21) else $error("ch2 stage"); // RULE9

   property p_win_open;
      @(posedge clk_sys) disable iff (!rst_b)
      (win_on && hit[4] && !hit[3] && !power_on_reset && !cfg_write)
         |=> trace_window_open;
   endproperty
   a_win_open: assert property (p_win_open) else $error("no open"); // RULE18

   property p_win_por;
      @(posedge clk_sys) disable iff (!rst_b)
      (trace_window_mode == WIN_5_TO_4_POR && power_on_reset)
         |=> !trace_window_open;
   endproperty
   a_win_por: assert property (p_win_por) else $error("por no close"); // RULE17

   property p_perf_acc;
      @(posedge clk_sys) disable iff (!rst_b)
      perf_active |=> perf_count == $past(perf_count) + 32'h0000_0001;
   endproperty
   a_perf_acc: assert property (p_perf_acc) else $error("perf lost"); // RULE15

   property p_count;
      @(posedge clk_sys) disable iff (!rst_b)
      (ch1_event && !count_done && !cfg_write) |=> occurrence != COUNT_RESET;
   endproperty
   a_count: assert property (p_count) else $error("early count"); // RULE5

endmodule // event_trigger_sequencer
`default_nettype wire

// >>> verification/core_bus_model.sv
// Purpose: Core bus model feeding data accesses and PC events
// Assumes: Every request starts just after a rising edge of clk_sys
// Notes: Released address, data and pc lines show the inverse of the last value; write and size hold
`timescale 1ns/1ps
`default_nettype none
module core_bus_model (
   // Clock
   input wire logic clk_sys,
   // Bus activity
   output logic access_valid,
   output logic [event_trigger_pkg::ADDR_W-1:0] access_addr,
   output logic [event_trigger_pkg::DATA_W-1:0] access_data,
   output logic access_write,
   output event_trigger_pkg::acc_size_t access_size,
   output logic pc_before_valid,
   output logic pc_after_valid,
   output logic [event_trigger_pkg::ADDR_W-1:0] pc
);
   import event_trigger_pkg::*;

   initial begin
      access_valid = 1'b0;
      access_addr = 32'h0000_0000;
      access_data = 32'h0000_0000;
      access_write = 1'b0;
      access_size = SIZE_LONG;
      pc_before_valid = 1'b0;
      pc_after_valid = 1'b0;
      pc = 32'h0000_0000;
   end

   // One access, then an idle edge so back-to-back calls never collide
   task automatic data_access(input logic [31:0] a, input logic [31:0] d,
                              input logic w, input acc_size_t s);
      access_valid <= 1'b1;
      access_addr <= a;
      access_data <= d;
      access_write <= w;
      access_size <= s;
      @(posedge clk_sys);
      access_valid <= 1'b0;
      access_addr <= ~a;
      access_data <= ~d;
      @(posedge clk_sys);
   endtask

   task automatic fetch(input logic [31:0] a, input logic after);
      pc <= a;
      pc_before_valid <= ~after;
      pc_after_valid <= after;
      @(posedge clk_sys);
      pc_before_valid <= 1'b0;
      pc_after_valid <= 1'b0;
      pc <= ~a;
      @(posedge clk_sys);
   endtask
endmodule // core_bus_model
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for the debug event-condition block
// Assumes: Bus model drives accesses; bench drives configuration
// Notes: Action pulses are counted, then compared per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import event_trigger_pkg::*;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic clk_sys, rst_b, power_on_reset, cpu_in_break, cfg_write;
   logic access_valid, access_write, pc_before_valid, pc_after_valid;
   logic [ADDR_W-1:0] access_addr, pc;
   logic [DATA_W-1:0] access_data;
   acc_size_t access_size;
   logic [NUM_CH-1:0] ch_enable, act_break, act_trace_halt, ch_hit;
   addr_src_t [NUM_CH-1:0] ch_addr_src;
   logic [NUM_CH-1:0][ADDR_W-1:0] ch_addr;
   logic [1:0] ch_data_enable, act_trace_qualify, seq_stage;
   logic [1:0][DATA_W-1:0] ch_data;
   acc_size_t [1:0] ch_data_size;
   acc_dir_t [1:0] ch_dir;
   logic ch1_count_enable, seq_halts_trace;
   logic [COUNT_W-1:0] ch1_count, occurrence;
   seq_mode_t seq_mode;
   win_mode_t trace_window_mode;
   logic break_req, trace_halt, trace_qualify, trace_window_open;
   logic perf_active, watchdog_timer_stop;
   logic [PERF_W-1:0] perf_count, v1;
   int err_total, n_compared, n_brk, n_halt, n_qual;
   // Data and direction cases: filter, size, access kind, data, expected
   acc_dir_t cs_dir [6] = '{DIR_WRITE, DIR_WRITE, DIR_READ, DIR_EITHER,
                            DIR_EITHER, DIR_EITHER};
   acc_size_t cs_size [6] = '{SIZE_LONG, SIZE_LONG, SIZE_LONG, SIZE_LONG,
                              SIZE_WORD, SIZE_BYTE};
   logic [5:0] cs_wr = 6'b010001;
   logic [5:0] cs_exp = 6'b110101;
   logic [31:0] cs_data [6] = '{32'hA5A5_1234, 32'hA5A5_1234, 32'hA5A5_1234,
                                32'hA5A5_1235, 32'hFFFF_1234, 32'hFFFF_FF34};
   seq_mode_t rp_mode [2] = '{SEQ_21_RP, SEQ_321_RP};

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   event_trigger_sequencer event_trigger_sequencer_i (.*);
   core_bus_model core_bus_model_i (.clk_sys, .access_valid, .access_addr,
      .access_data, .access_write, .access_size, .pc_before_valid,
      .pc_after_valid, .pc);

   always @(posedge clk_sys) begin
      n_brk += int'(break_req === 1'b1);
      n_halt += int'(trace_halt === 1'b1);
      n_qual += int'(trace_qualify === 1'b1);
   end
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   function automatic logic [31:0] chaddr(input int k);
      return 32'h0000_1000 + 32'(k * 16);
   endfunction

   // Defaults under a raised cfg_write; apply() lowers it
   task automatic base_cfg();
      cfg_write <= 1'b1;
      ch_enable <= 11'h000;
      act_break <= 11'h000;
      act_trace_halt <= 11'h000;
      act_trace_qualify <= 2'h0;
      for (int k = 0; k < NUM_CH; k++) begin
         ch_addr[k] <= chaddr(k);
         ch_addr_src[k] <= ADDR_DATA;
      end
      ch_data_enable <= 2'h0;
      ch_data <= '0;
      ch_data_size <= {SIZE_LONG, SIZE_LONG};
      ch_dir <= {DIR_EITHER, DIR_EITHER};
      ch1_count_enable <= 1'b0;
      ch1_count <= 16'h0000;
      seq_mode <= SEQ_OFF;
      seq_halts_trace <= 1'b0;
      trace_window_mode <= WIN_OFF;
      @(posedge clk_sys);
   endtask

   task automatic apply();
      cfg_write <= 1'b1;
      @(posedge clk_sys);
      cfg_write <= 1'b0;
      acts(0, 0, 0);
   endtask

   task automatic send(input int k);
      core_bus_model_i.data_access(chaddr(k), 32'h0, 1'b0, SIZE_LONG);
   endtask

   // Answer lands two cycles after the access; three edges cover it
   task automatic acts(input int b, input int h, input int q);
      repeat (3) @(posedge clk_sys);
      check(n_brk, b, "break pulses");
      check(n_halt, h, "trace halt pulses");
      check(n_qual, q, "trace qualify pulses");
      n_brk = 0;
      n_halt = 0;
      n_qual = 0;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      power_on_reset = 1'b0;
      cpu_in_break = 1'b0;
      base_cfg();
      @(posedge clk_sys);
      rst_b <= 1'b1;
      check(perf_count, 32'h0, "perf after reset");
      check(seq_stage, 2'h0, "stage after reset");
      apply();
      base_cfg();
      ch_enable <= 11'h025;
      act_break <= 11'h025;
      ch_addr_src[2] <= ADDR_PC_BEFORE;
      ch_addr_src[5] <= ADDR_PC_AFTER;
      apply();
      send(0); acts(1, 0, 0);
      core_bus_model_i.data_access(chaddr(0) + 4, 32'h0, 1'b0, SIZE_LONG);
      acts(0, 0, 0);
      core_bus_model_i.fetch(chaddr(2), 1'b0); acts(1, 0, 0);
      core_bus_model_i.fetch(chaddr(2), 1'b1); acts(0, 0, 0);
      core_bus_model_i.fetch(chaddr(5), 1'b1); acts(1, 0, 0);
      send(2); acts(0, 0, 0);
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 6; i++) begin
            base_cfg();
            ch_enable[c] <= 1'b1;
            act_break[c] <= 1'b1;
            ch_data_enable[c] <= 1'b1;
            ch_data[c] <= 32'hA5A5_1234;
            ch_data_size[c] <= cs_size[i];
            ch_dir[c] <= cs_dir[i];
            apply();
            core_bus_model_i.data_access(chaddr(c), cs_data[i], cs_wr[i],
                                         cs_size[i]);
            acts(int'(cs_exp[i]), 0, 0);
         end
      end
      for (int k = 0; k < NUM_CH; k++) begin
         base_cfg();
         ch_enable <= NUM_CH'(1) << k;
         act_break <= NUM_CH'(1) << k;
         act_trace_halt <= NUM_CH'(1) << k;
         apply();
         send(k); #1 check(ch_hit, 32'h1 << k, "hit");
         acts(1, 1, 0);
      end
      base_cfg();
      ch_enable <= 11'h002;
      act_trace_qualify <= 2'b10;
      apply();
      send(1); acts(0, 0, 1);
      base_cfg();
      ch_enable <= 11'h001;
      act_break <= 11'h001;
      ch1_count_enable <= 1'b1;
      ch1_count <= 16'h0003;
      apply();
      send(0); send(0); acts(0, 0, 0);
      check(occurrence, 32'h2, "count");
      send(0); acts(1, 0, 0);
      for (int h = 0; h < 2; h++) begin
         base_cfg();
         seq_mode <= SEQ_321;
         seq_halts_trace <= h[0];
         ch_enable <= 11'h007;
         act_break <= 11'h007;
         apply();
         send(0); send(1); send(2); acts(0, 0, 0);
         check(seq_stage, 2'h1, "stage after third channel");
         send(1); send(0); acts(1 - h, h, 0);
      end
      base_cfg();
      seq_mode <= SEQ_21;
      ch_enable <= 11'h003;
      ch1_count_enable <= 1'b1;
      ch1_count <= 16'h0002;
      apply();
      send(0); send(1); @(posedge clk_sys);
      check(seq_stage, 2'h2, "stage wait");
      send(0); acts(0, 0, 0);
      send(1); send(0); acts(1, 0, 0);
      send(1); apply();
      check(seq_stage, 2'h0, "stage after config write");
      send(0); send(1); send(0); acts(0, 0, 0);
      for (int r = 0; r < 2; r++) begin
         base_cfg();
         seq_mode <= rp_mode[r];
         ch_enable <= 11'h407;
         act_break <= 11'h400;
         apply();
         if (r == 1) send(2);
         send(1); send(10); send(0); acts(0, 0, 0);
         if (r == 1) send(2);
         send(1); send(0); acts(1, 0, 0);
      end
      for (int m = 0; m < 2; m++) begin
         base_cfg();
         seq_mode <= (m == 0) ? PERF_2_TO_1 : PERF_1_TO_2;
         ch_enable <= 11'h003;
         apply();
         send(1 - m); acts(0, 0, 0);
         check(perf_active, 1'b1, "perf running");
         send(m); acts(0, 0, 0);
         check(perf_active, 1'b0, "perf stopped");
         v1 = perf_count;
         check(32'(v1 > 32'h4), 32'h1, "perf measured");
         send(1 - m); repeat (5) @(posedge clk_sys); send(m); acts(0, 0, 0);
         check(32'(perf_count > v1 + 32'h4), 32'h1, "perf added");
      end
      base_cfg();
      trace_window_mode <= WIN_5_TO_4;
      ch_enable <= 11'h018;
      act_break <= 11'h018;
      apply();
      send(4); acts(0, 0, 0);
      check(trace_window_open, 1'b1, "window opened");
      send(3); acts(0, 0, 0);
      check(trace_window_open, 1'b0, "window closed");
      send(4); acts(0, 0, 0);
      check(trace_window_open, 1'b1, "window reopened");
      base_cfg();
      trace_window_mode <= WIN_5_TO_4_POR;
      ch_enable <= 11'h018;
      apply();
      send(4); acts(0, 0, 0);
      check(trace_window_open, 1'b1, "window opened");
      power_on_reset <= 1'b1;
      @(posedge clk_sys);
      power_on_reset <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(trace_window_open, 1'b0, "closed by power-on");
      cpu_in_break <= 1'b1;
      repeat (2) @(posedge clk_sys);
      check(watchdog_timer_stop, 1'b1, "watchdog held");
      cpu_in_break <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check(watchdog_timer_stop, 1'b0, "watchdog free");
      summarize();
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      summarize();
   end
endmodule // tb_top
`default_nettype wire
